//--- logic/dio_pkg.sv
// Package: constants and carrier types for the eight-channel diagnostic input block
package dio_pkg;
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned NUM_CH          = 8;
	// Input delay choices in microseconds
	localparam int unsigned DLY_0P5_US      = 500;
	localparam int unsigned DLY_3_US        = 3_000;
	localparam int unsigned DLY_15_US       = 15_000;
	localparam int unsigned DLY_20_US       = 20_000;
	localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
	localparam int unsigned DLY_0P5_CYC     = DLY_0P5_US * CYC_PER_US;
	localparam int unsigned DLY_3_CYC       = DLY_3_US * CYC_PER_US;
	localparam int unsigned DLY_15_CYC      = DLY_15_US * CYC_PER_US;
	localparam int unsigned DLY_20_CYC      = DLY_20_US * CYC_PER_US;
	localparam int unsigned CNT_W           = 20;

	typedef enum logic [1:0] {DLY_0P5, DLY_3, DLY_15, DLY_20} in_delay_e;
	localparam in_delay_e   DLY_RESET       = DLY_3;

	// Per-channel configuration, all off after reset
	typedef struct packed {
		logic [7:0] short_det_en;
		logic [7:0] break_det_en;
		logic [7:0] rise_irq_en;
		logic [7:0] fall_irq_en;
	} ch_cfg_s;
	localparam ch_cfg_s     CH_CFG_RESET    = '0;

	// Module-wide configuration
	typedef struct packed {
		in_delay_e  in_delay;
		logic       diag_irq_en;
		logic       hw_irq_en;
	} mod_cfg_s;
	localparam mod_cfg_s    MOD_CFG_RESET   = '{in_delay: DLY_RESET, diag_irq_en: 1'b0,
		hw_irq_en: 1'b0};
endpackage

//--- logic/dio_filter.sv
// Symmetric debounce filter for one input channel
`timescale 1ns/10ps
`default_nettype none
module dio_filter
	import dio_pkg::*;
#(
	parameter int unsigned W = CNT_W
)
(
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// Synchronised raw level and required stable time
	input  wire logic         raw_in,
	input  wire logic [W-1:0] limit,
	// Filtered level
	output logic              level
);
	// A one-bit count could not tell a running count from a finished one
	if (W < 2)
	begin : g_bad_w
		$error("Counter width too small");
	end

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         lvl_reg;
	logic         lvl_next;

	// Both directions need the input to differ for limit cycles in a row
	always_comb
	begin
		cnt_next = '0;
		lvl_next = lvl_reg;
		if (raw_in != lvl_reg)
		begin
			if (cnt_reg + W'(1) >= limit)
				lvl_next = raw_in;
			else
				cnt_next = cnt_reg + W'(1);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cnt_reg <= '0;
			lvl_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			lvl_reg <= lvl_next;
		end
	end

	assign level = lvl_reg;
endmodule // dio_filter
`default_nettype wire

//--- logic/dio_input_module.sv
// Eight-channel digital input block with filtering, diagnostics and edge interrupts
// Function
// - One selectable input delay, 3 ms after reset
// - Delay filters rising and falling transitions alike
// - Per-channel short-to-ground detect enable, default off
// - Short/break raise diagnostic interrupt where enabled
// - Per-channel rising/falling edge hardware interrupts
// - Edge enables only settable with module enable
// - One indicator per channel shows filtered state
`timescale 1ns/10ps
`default_nettype none
module dio_input_module
	import dio_pkg::*;
#(
	parameter int unsigned CH = NUM_CH
)
(
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst,
	// Sensor inputs and analog fault comparators (asynchronous)
	input  wire logic [CH-1:0] sensor_in,
	input  wire logic [CH-1:0] short_sense,
	input  wire logic [CH-1:0] break_sense,
	// Configuration from the basic module, sampled when cfg_load is high
	input  wire logic          cfg_load,
	input  wire mod_cfg_s      mod_cfg_in,
	input  wire ch_cfg_s       ch_cfg_in,
	// Status
	output logic [CH-1:0]      status_led,
	output logic [CH-1:0]      fault_led,
	output logic [CH-1:0]      ch_state,
	// Interrupt pulses
	output logic [CH-1:0]      hw_irq_rise,
	output logic [CH-1:0]      hw_irq_fall,
	output logic [CH-1:0]      diag_irq
);
	// Per-channel fields of the carriers are fixed at eight bits
	if (CH != NUM_CH)
	begin : g_bad_ch
		$error("Channel count must be eight");
	end
	// The longest delay has to fit the shared counter width
	if (DLY_20_CYC >= (64'h1 << CNT_W))
	begin : g_bad_cnt
		$error("Delay counter too narrow for the longest delay");
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration
	mod_cfg_s mod_reg;
	mod_cfg_s mod_next;
	ch_cfg_s  ch_reg;
	ch_cfg_s  ch_next;

	always_comb
	begin
		mod_next = mod_reg;
		ch_next  = ch_reg;
		if (cfg_load)
		begin
			mod_next = mod_cfg_in;
			ch_next  = ch_cfg_in;
			// Edge enables are dropped unless the module enable comes with them
			if (!mod_cfg_in.hw_irq_en)
			begin
				ch_next.rise_irq_en = '0;
				ch_next.fall_irq_en = '0;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			mod_reg <= MOD_CFG_RESET;
			ch_reg  <= CH_CFG_RESET;
		end
		else
		begin
			mod_reg <= mod_next;
			ch_reg  <= ch_next;
		end
	end

	function automatic logic [CNT_W-1:0] delay_cycles(input in_delay_e sel);
		unique case (sel)
			DLY_0P5: delay_cycles = CNT_W'(DLY_0P5_CYC);
			DLY_3:   delay_cycles = CNT_W'(DLY_3_CYC);
			DLY_15:  delay_cycles = CNT_W'(DLY_15_CYC);
			DLY_20:  delay_cycles = CNT_W'(DLY_20_CYC);
		endcase
	endfunction

	logic [CNT_W-1:0] limit;
	assign limit = delay_cycles(mod_reg.in_delay);

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers and filters
	logic [CH-1:0] in_s1_reg;
	logic [CH-1:0] in_s2_reg;
	logic [CH-1:0] sh_s1_reg;
	logic [CH-1:0] sh_s2_reg;
	logic [CH-1:0] br_s1_reg;
	logic [CH-1:0] br_s2_reg;
	logic [CH-1:0] filt;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			in_s1_reg <= '0;
			in_s2_reg <= '0;
			sh_s1_reg <= '0;
			sh_s2_reg <= '0;
			br_s1_reg <= '0;
			br_s2_reg <= '0;
		end
		else
		begin
			in_s1_reg <= sensor_in;
			in_s2_reg <= in_s1_reg;
			sh_s1_reg <= short_sense;
			sh_s2_reg <= sh_s1_reg;
			br_s1_reg <= break_sense;
			br_s2_reg <= br_s1_reg;
		end
	end

	for (genvar i = 0; i < CH; i++)
	begin : g_ch
		dio_filter #(.W(CNT_W)) u_filt
		(
			.sys_clk (sys_clk),
			.rst     (rst),
			.raw_in  (in_s2_reg[i]),
			.limit   (limit),
			.level   (filt[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs and events
	logic [CH-1:0] prev_reg;
	logic [CH-1:0] fault;
	logic [CH-1:0] fault_reg;
	logic [CH-1:0] rise_next;
	logic [CH-1:0] fall_next;
	logic [CH-1:0] diag_next;
	logic [CH-1:0] rise_reg;
	logic [CH-1:0] fall_reg;
	logic [CH-1:0] diag_reg;
	logic [CH-1:0] led_reg;

	always_comb
	begin
		fault     = (sh_s2_reg & ch_reg.short_det_en) | (br_s2_reg & ch_reg.break_det_en);
		// Edge enables already imply the module enable; checked again for clarity
		rise_next = {CH{mod_reg.hw_irq_en}} & ch_reg.rise_irq_en & filt & ~prev_reg;
		fall_next = {CH{mod_reg.hw_irq_en}} & ch_reg.fall_irq_en & ~filt & prev_reg;
		// Interrupt only on a new fault, not while it persists
		diag_next = {CH{mod_reg.diag_irq_en}} & fault & ~fault_reg;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			prev_reg  <= '0;
			fault_reg <= '0;
			rise_reg  <= '0;
			fall_reg  <= '0;
			diag_reg  <= '0;
			led_reg   <= '0;
		end
		else
		begin
			prev_reg  <= filt;
			fault_reg <= fault;
			rise_reg  <= rise_next;
			fall_reg  <= fall_next;
			diag_reg  <= diag_next;
			led_reg   <= filt;
		end
	end

	assign status_led  = led_reg;
	assign ch_state    = led_reg;
	assign fault_led   = fault_reg;
	assign hw_irq_rise = rise_reg;
	assign hw_irq_fall = fall_reg;
	assign diag_irq    = diag_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_rise(int k);
		!prev_reg[k] ##0 filt[k];
	endsequence

	AST_RESET_DELAY: assert property (@(posedge sys_clk)
		$fell(rst) |-> mod_reg.in_delay == DLY_3)
		else $error("Delay not 3 ms after reset");
	AST_LIMIT_MATCH: assert property (@(posedge sys_clk) disable iff (rst)
		mod_reg.in_delay == DLY_0P5 |-> limit == CNT_W'(DLY_0P5_CYC))
		else $error("Short delay count wrong");
	// Checked per bit: other channels may still be counting when one moves
	AST_SYMMETRIC: assert property (@(posedge sys_clk) disable iff (rst)
		((filt ^ $past(filt)) & (filt ^ $past(in_s2_reg))) == '0)
		else $error("Filter moved without stable input");
	AST_SHORT_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		ch_reg.short_det_en == '0 && ch_reg.break_det_en == '0 |=> diag_irq == '0)
		else $error("Diagnostic with detection off");
	AST_DIAG_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		!mod_reg.diag_irq_en |=> diag_irq == '0)
		else $error("Diagnostic interrupt while disabled");
	AST_RISE_EDGE: assert property (@(posedge sys_clk) disable iff (rst)
		s_rise(0) ##0 ch_reg.rise_irq_en[0] |=> hw_irq_rise[0])
		else $error("Rising edge interrupt missed");
	AST_EN_GATED: assert property (@(posedge sys_clk) disable iff (rst)
		!mod_reg.hw_irq_en |-> ch_reg.rise_irq_en == '0 && ch_reg.fall_irq_en == '0)
		else $error("Edge enable set without module enable");
	AST_LED: assert property (@(posedge sys_clk) disable iff (rst)
		##1 status_led == $past(filt))
		else $error("Indicator does not follow state");
	AST_FILTERED_EDGE: assert property (@(posedge sys_clk) disable iff (rst)
		hw_irq_rise[0] |-> led_reg[0] && $past(filt[0], 2) == 1'b0)
		else $error("Edge not from filtered state");
endmodule // dio_input_module
`default_nettype wire

//--- test/backplane_model.sv
// Partner model: basic module loading parameters across the backplane
`timescale 1ns/10ps
`default_nettype none
module backplane_model
	import dio_pkg::*;
(
	// Clock
	input  wire logic   sys_clk,
	// Parameter load
	output var logic     cfg_load,
	output var mod_cfg_s mod_cfg,
	output var ch_cfg_s  ch_cfg
);
	initial
	begin
		cfg_load = 1'b0;
		mod_cfg = MOD_CFG_RESET;
		ch_cfg = CH_CFG_RESET;
	end
	// Data is inverted once the strobe drops so stale values never look valid
	task automatic load(input mod_cfg_s m, input ch_cfg_s c);
		@(posedge sys_clk);
		cfg_load <= 1'b1;
		mod_cfg <= m;
		ch_cfg <= c;
		@(posedge sys_clk);
		cfg_load <= 1'b0;
		mod_cfg <= ~m;
		ch_cfg <= ~c;
	endtask
endmodule // backplane_model
`default_nettype wire

//--- test/dio_input_module_tb.sv
// Testbench for the eight-channel diagnostic input block
`timescale 1ns/10ps
`default_nettype none
module dio_input_module_tb
	import dio_pkg::*;
;
	localparam int N = DLY_0P5_CYC;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sensor_in = 8'h00;
	logic [7:0] short_sense = 8'h00;
	logic [7:0] break_sense = 8'h00;
	logic cfg_load;
	mod_cfg_s mc;
	ch_cfg_s cc;
	logic [7:0] led, fled, st, ir, ifl, dg;
	int n_mismatch = 0;
	int checks = 0;
	int rc, fc, dc;
	always #25 sys_clk = ~sys_clk;
	backplane_model bm (.sys_clk(sys_clk), .cfg_load(cfg_load), .mod_cfg(mc), .ch_cfg(cc));
	dio_input_module dio_input_module_i (.sys_clk(sys_clk), .rst(rst), .sensor_in(sensor_in),
		.short_sense(short_sense), .break_sense(break_sense), .cfg_load(cfg_load),
		.mod_cfg_in(mc), .ch_cfg_in(cc), .status_led(led), .fault_led(fled), .ch_state(st),
		.hw_irq_rise(ir), .hw_irq_fall(ifl), .diag_irq(dg));
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [47:0] e, input logic [47:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Pulses are one cycle wide, so one look per cycle counts every one
	task automatic watch(input int n);
		rc = 0;
		fc = 0;
		dc = 0;
		repeat (n)
		begin
			@(posedge sys_clk);
			#1;
			rc += $countones(ir);
			fc += $countones(ifl);
			dc += $countones(dg);
		end
	endtask
	task automatic t_default;
		#1;
		cmp("outputs", 48'h0, {led, fled, st, ir, ifl, dg});
		@(posedge sys_clk) sensor_in <= 8'h01;
		watch(N + 2000);
		cmp("status_led", 8'h00, led);
		@(posedge sys_clk) sensor_in <= 8'h00;
		watch(4);
		bm.load('{DLY_0P5, 1'b0, 1'b1}, '{8'h00, 8'h00, 8'h01, 8'h01});
		$display("done default");
	endtask
	// Long delays would outlast the run, so the count in use is compared
	task automatic t_delay;
		bm.load('{DLY_15, 1'b0, 1'b0}, CH_CFG_RESET);
		#1;
		cmp("limit 15 ms", 48'(DLY_15_CYC), 48'(dio_input_module_i.limit));
		bm.load('{DLY_20, 1'b0, 1'b0}, CH_CFG_RESET);
		#1;
		cmp("limit 20 ms", 48'(DLY_20_CYC), 48'(dio_input_module_i.limit));
		bm.load('{DLY_3, 1'b0, 1'b0}, CH_CFG_RESET);
		#1;
		cmp("limit 3 ms", 48'(DLY_3_CYC), 48'(dio_input_module_i.limit));
		$display("done delay");
	endtask
	task automatic t_edge(input logic [7:0] v);
		@(posedge sys_clk) sensor_in <= v;
		watch(N + 6);
		cmp("status_led", v, led);
		cmp("ch_state", v, st);
		cmp("rise", 48'(v[0]), 48'(rc));
		cmp("fall", 48'(!v[0]), 48'(fc));
		$display("done edge");
	endtask
	task automatic t_glitch;
		@(posedge sys_clk) sensor_in <= 8'h01;
		repeat (N / 2) @(posedge sys_clk);
		sensor_in <= 8'h00;
		watch(N + 6);
		cmp("glitch", 48'h0, {led, 8'(rc), 8'(fc)});
		$display("done glitch");
	endtask
	task automatic t_gate;
		bm.load('{DLY_0P5, 1'b0, 1'b0}, '{8'h00, 8'h00, 8'hff, 8'hff});
		@(posedge sys_clk) sensor_in <= 8'hff;
		watch(N + 6);
		cmp("gated rise", 48'h0, 48'(rc));
		cmp("status_led", 8'hff, led);
		$display("done gate");
	endtask
	task automatic t_fault;
		@(posedge sys_clk) short_sense <= 8'h03;
		watch(6);
		cmp("short off", 48'h0, {fled, 8'(dc)});
		// Faults are raised only once watching runs, so the one-cycle pulse is seen
		@(posedge sys_clk) short_sense <= 8'h00;
		watch(4);
		bm.load('{DLY_0P5, 1'b1, 1'b0}, '{8'h02, 8'h04, 8'h00, 8'h00});
		@(posedge sys_clk);
		short_sense <= 8'h03;
		break_sense <= 8'h04;
		watch(6);
		cmp("fault_led", 8'h06, fled);
		cmp("diag", 48'h2, 48'(dc));
		$display("done fault");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_default();
		t_edge(8'h01);
		t_edge(8'h00);
		t_glitch();
		t_delay();
		t_gate();
		t_fault();
		final_report();
	end
	// Whole run is about 57000 cycles
	initial
	begin
		#(90_000 * 50);
		n_mismatch++;
		final_report();
	end
endmodule // dio_input_module_tb
`default_nettype wire
